// ==== inc/shiftreg_pkg.sv ====
`default_nettype none
// Shared constants for the bidirectional shift register
package shiftreg_pkg;

  // Default register width (number of parallel inputs and outputs)
  localparam int WIDTH_DEF  = 8;
  // Default width of the shift event counter
  localparam int COUNT_DEF  = 16;

  // Avalon-MM geometry, byte addresses, one 32-bit word per register
  localparam int ADDR_W     = 5;
  localparam int DATA_W     = 32;
  localparam int BE_W       = 4;

  // Register offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_INIT   = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_COUNT  = 5'h0C;
  localparam logic [4:0] OFS_PINS   = 5'h10;

  // Control register fields
  localparam int CTRL_ASYNC_LOAD_SELECT_BIT   = 0;
  localparam int CTRL_ASYNC_RESET_SELECT_BIT  = 1;
  localparam int CTRL_RESTART_BIT = 2;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0003;

  // Pin snapshot register fields
  localparam int PINS_LOW_BIT  = 0;
  localparam int PINS_HIGH_BIT = 1;
  localparam int PINS_OE_BIT   = 2;
  localparam int PINS_HOLD_BIT = 3;
  localparam int PINS_UP_BIT   = 4;

  // Reset values and the answer to an unmapped read
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] INIT_RST    = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

  // Operation applied to the register contents in one cycle
  typedef enum logic [2:0] {
    OP_IDLE  = 3'b000,
    OP_CLEAR = 3'b001,
    OP_LOAD  = 3'b010,
    OP_UP    = 3'b011,
    OP_DOWN  = 3'b100,
    OP_INIT  = 3'b101
  } op_t;

endpackage
`default_nettype wire

// ==== inc/shift_core_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Carries one cycle's operation between control and the shift core
interface shift_core_if #(
  parameter int WIDTH = shiftreg_pkg::WIDTH_DEF
);
  shiftreg_pkg::op_t  op;        // Selected operation
  logic [WIDTH-1:0]   cur;       // Present contents
  logic [WIDTH-1:0]   par_in;    // Parallel load data
  logic [WIDTH-1:0]   init_val;  // Initial value
  logic               lower_in;  // Fill bit for upward shift
  logic               upper_in;  // Fill bit for downward shift
  logic [WIDTH-1:0]   nxt;       // Next contents

  // Control side
  modport ctrl (output op, cur, par_in, init_val, lower_in, upper_in,
                input nxt);
  // Core side
  modport core (input op, cur, par_in, init_val, lower_in, upper_in,
                output nxt);
endinterface
`default_nettype wire

// ==== src/shift_register_primitive.sv ====
`timescale 1ns/1ps
`default_nettype none
// Next-state datapath of the shift register, purely combinational
module shift_register_primitive #(
  parameter int WIDTH = shiftreg_pkg::WIDTH_DEF
) (
  // Operation and data from the control module
  shift_core_if.core cif
);

  // One case per operation; the caller has already resolved priority
  always_comb begin
    case (cif.op)
      shiftreg_pkg::OP_CLEAR: begin
        cif.nxt = '0;
      end
      shiftreg_pkg::OP_INIT: begin
        cif.nxt = cif.init_val;
      end
      shiftreg_pkg::OP_LOAD: begin
        cif.nxt = cif.par_in;
      end
      shiftreg_pkg::OP_UP: begin
        // Bits move toward the top, bottom filled serially
        cif.nxt = {cif.cur[WIDTH-2:0], cif.lower_in};
      end
      shiftreg_pkg::OP_DOWN: begin
        // Bits move toward the bottom, top filled serially
        cif.nxt = {cif.upper_in, cif.cur[WIDTH-1:1]};
      end
      default: begin
        // Idle keeps the contents
        cif.nxt = cif.cur;
      end
    endcase
  end

endmodule
`default_nettype wire

// ==== src/bidirectional_shift_register.sv ====
`timescale 1ns/1ps
`default_nettype none
module bidirectional_shift_register #(
  parameter int WIDTH   = shiftreg_pkg::WIDTH_DEF,
  parameter int COUNT_W = shiftreg_pkg::COUNT_DEF
) (
  // System
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic                            clk_en,
  // Avalon-MM slave
  input  wire logic [shiftreg_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                            avs_read,
  input  wire logic                            avs_write,
  input  wire logic [shiftreg_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [shiftreg_pkg::BE_W-1:0]   avs_byteenable,
  output logic      [shiftreg_pkg::DATA_W-1:0] avs_readdata,
  output logic                                 avs_waitrequest,
  // Shift control pins
  input  wire logic                            shift_clk,
  input  wire logic                            dir_up,
  input  wire logic                            hold,
  input  wire logic                            load,
  input  wire logic                            clear,
  input  wire logic                            out_en,
  // Data inputs
  input  wire logic [WIDTH-1:0]                par_in,
  input  wire logic                            lower_serial_in,
  input  wire logic                            upper_serial_in,
  // Data outputs
  output logic      [WIDTH-1:0]                par_out,
  output logic                                 par_out_oe,
  output logic                                 low_serial_out,
  output logic                                 high_serial_out
);

  // Register contents, the heart of the block
  logic [WIDTH-1:0]   contents_q;
  // Previous level of the shift clock pin, for edge finding
  logic               shift_clk_q;
  // Registered parallel output enable
  logic               par_oe_q;
  // Control register: mode flags
  logic               async_load_select_q;
  logic               async_reset_select_q;
  // One-shot request to reload the initial value
  logic               restart_q;
  // Initial value register
  logic [WIDTH-1:0]   init_q;
  // Count of shifts performed, wraps
  logic [COUNT_W-1:0] shift_count_q;
  // Bus answer state
  logic               waitreq_q;
  logic [31:0]        rdata_q;

  // Decoded events of this cycle
  logic               shift_edge;
  logic               bus_req;
  logic               bus_done;
  logic               wr_ctrl;
  logic               wr_init;
  logic [31:0]        be_mask;
  logic [31:0]        ctrl_word;
  logic [31:0]        ctrl_new;
  logic [31:0]        init_new;
  logic [31:0]        rd_word;
  logic               clear_req;
  logic               load_req;
  logic               shift_req;
  shiftreg_pkg::op_t  op_sel;

  // Link to the datapath core
  shift_core_if #(.WIDTH(WIDTH)) cif ();

  shift_register_primitive #(
    .WIDTH (WIDTH)
  ) u_core (
    .cif (cif)
  );

  // ---------------------------------------------------------------
  // Shift clock edge detection
  // ---------------------------------------------------------------

  // Pin is synchronous to clk, so one stored level is enough
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_clk_q <= 1'b0;
    end else if (clk_en) begin
      shift_clk_q <= shift_clk;
    end
  end

  // Rising edge of the shift clock marks a shift moment
  assign shift_edge = shift_clk & ~shift_clk_q;

  // ---------------------------------------------------------------
  // Operation requests and their priority
  // ---------------------------------------------------------------

  // Immediate reset acts in this cycle, else waits for an edge
  assign clear_req = clear &
                     (async_reset_select_q | shift_edge);

  // Immediate load likewise ignores the shift clock
  assign load_req  = load &
                     (async_load_select_q | shift_edge);

  // Shifting needs an edge and hold released
  assign shift_req = shift_edge & ~hold;

  // Reset beats load, load beats shift; none look at out_en
  always_comb begin
    if (restart_q) begin
      // Software restart reloads the initial value
      op_sel = shiftreg_pkg::OP_INIT;
    end else if (clear_req) begin
      op_sel = shiftreg_pkg::OP_CLEAR;
    end else if (load_req) begin
      op_sel = shiftreg_pkg::OP_LOAD;
    end else if (shift_req) begin
      // Direction high means upward
      if (dir_up) begin
        op_sel = shiftreg_pkg::OP_UP;
      end else begin
        op_sel = shiftreg_pkg::OP_DOWN;
      end
    end else begin
      // Nothing requested, contents stand
      op_sel = shiftreg_pkg::OP_IDLE;
    end
  end

  // Feed the core with present state and inputs
  assign cif.op       = op_sel;
  assign cif.cur      = contents_q;
  assign cif.par_in   = par_in;
  assign cif.init_val = init_q;
  assign cif.lower_in = lower_serial_in;
  assign cif.upper_in = upper_serial_in;

  // ---------------------------------------------------------------
  // Register contents
  // ---------------------------------------------------------------

  // Takes the core result every enabled cycle; out_en not involved
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Start of operation: initial value register is at reset value
      contents_q <= shiftreg_pkg::INIT_RST[WIDTH-1:0];
    end else if (clk_en) begin
      contents_q <= cif.nxt;
    end
  end

  // Shift counter, visible to software as a sign of life
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_count_q <= '0;
    end else if (clk_en) begin
      // Only real shifts count, not loads or clears
      if (op_sel == shiftreg_pkg::OP_UP ||
          op_sel == shiftreg_pkg::OP_DOWN) begin
        shift_count_q <= shift_count_q + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output enable
  // ---------------------------------------------------------------

  // Registered so that every output comes from a flop; costs a cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      par_oe_q <= 1'b0;
    end else if (clk_en) begin
      par_oe_q <= out_en;
    end
  end

  // Parallel data always carry contents; enable marks drive or Z
  assign par_out    = contents_q;
  assign par_out_oe = par_oe_q;

  // Serial outputs follow the end bits, never gated
  assign low_serial_out  = contents_q[0];
  assign high_serial_out = contents_q[WIDTH-1];

  // ---------------------------------------------------------------
  // Avalon-MM slave: one wait cycle on every access
  // ---------------------------------------------------------------

  // A request is pending while read or write is high
  assign bus_req  = avs_read | avs_write;
  // The answering cycle: waitrequest low with request still held
  assign bus_done = bus_req & ~waitreq_q;

  // Write strobes take effect only at the answering edge
  assign wr_ctrl = bus_done & avs_write &
                   (avs_address == shiftreg_pkg::OFS_CTRL);
  assign wr_init = bus_done & avs_write &
                   (avs_address == shiftreg_pkg::OFS_INIT);

  // Expand byte enables into a bit mask
  always_comb begin
    for (int b = 0; b < shiftreg_pkg::BE_W; b++) begin
      be_mask[b*8 +: 8] = {8{avs_byteenable[b]}};
    end
  end

  // Present control word, reserved bits zero
  always_comb begin
    ctrl_word = '0;
    ctrl_word[shiftreg_pkg::CTRL_ASYNC_LOAD_SELECT_BIT]  = async_load_select_q;
    ctrl_word[shiftreg_pkg::CTRL_ASYNC_RESET_SELECT_BIT] = async_reset_select_q;
  end

  // Merge written bytes with the old contents
  assign ctrl_new = (ctrl_word & ~be_mask) | (avs_writedata & be_mask);
  assign init_new = (32'(init_q) & ~be_mask) |
                    (avs_writedata & be_mask);

  // Wait state: high at rest, low for the one answering cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitreq_q <= 1'b1;
    end else if (clk_en) begin
      // Release on the edge that first sees the request
      if (bus_req && waitreq_q) begin
        waitreq_q <= 1'b0;
      end else begin
        waitreq_q <= 1'b1;
      end
    end
  end

  // Mode flags select synchronous or immediate load and reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      async_load_select_q  <=
        shiftreg_pkg::CTRL_RST[shiftreg_pkg::CTRL_ASYNC_LOAD_SELECT_BIT];
      async_reset_select_q <=
        shiftreg_pkg::CTRL_RST[shiftreg_pkg::CTRL_ASYNC_RESET_SELECT_BIT];
    end else if (clk_en && wr_ctrl) begin
      async_load_select_q  <= ctrl_new[shiftreg_pkg::CTRL_ASYNC_LOAD_SELECT_BIT];
      async_reset_select_q <= ctrl_new[shiftreg_pkg::CTRL_ASYNC_RESET_SELECT_BIT];
    end
  end

  // Restart is a self-clearing pulse; used in the cycle after write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      restart_q <= 1'b0;
    end else if (clk_en) begin
      restart_q <= wr_ctrl &
                   ctrl_new[shiftreg_pkg::CTRL_RESTART_BIT];
    end
  end

  // Initial value register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      init_q <= shiftreg_pkg::INIT_RST[WIDTH-1:0];
    end else if (clk_en && wr_init) begin
      init_q <= init_new[WIDTH-1:0];
    end
  end

  // Read multiplexer; unmapped offsets answer with zero
  always_comb begin
    rd_word = shiftreg_pkg::UNMAPPED_RD;
    case (avs_address)
      shiftreg_pkg::OFS_CTRL: begin
        rd_word = ctrl_word;
      end
      shiftreg_pkg::OFS_INIT: begin
        rd_word = 32'(init_q);
      end
      shiftreg_pkg::OFS_STATUS: begin
        // Live contents, independent of the output enable
        rd_word = 32'(contents_q);
      end
      shiftreg_pkg::OFS_COUNT: begin
        rd_word = 32'(shift_count_q);
      end
      shiftreg_pkg::OFS_PINS: begin
        rd_word[shiftreg_pkg::PINS_LOW_BIT]  = contents_q[0];
        rd_word[shiftreg_pkg::PINS_HIGH_BIT] = contents_q[WIDTH-1];
        rd_word[shiftreg_pkg::PINS_OE_BIT]   = par_oe_q;
        rd_word[shiftreg_pkg::PINS_HOLD_BIT] = hold;
        rd_word[shiftreg_pkg::PINS_UP_BIT]   = dir_up;
      end
      default: begin
        rd_word = shiftreg_pkg::UNMAPPED_RD;
      end
    endcase
  end

  // Read data captured on the edge that first sees the request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (clk_en) begin
      if (avs_read && waitreq_q) begin
        rdata_q <= rd_word;
      end
    end
  end

  // Bus outputs straight from flops
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = waitreq_q;

endmodule
`default_nettype wire

// ==== tb/shiftreg_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// Pin-level watch on the shift register
module shiftreg_checker #(
  parameter int WIDTH   = 8,
  parameter int COUNT_W = 16
) (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             clk_en,
  input wire logic             avs_write,
  input wire logic             shift_clk,
  input wire logic             dir_up,
  input wire logic             hold,
  input wire logic             load,
  input wire logic             clear,
  input wire logic             out_en,
  input wire logic [WIDTH-1:0] par_in,
  input wire logic             lower_serial_in,
  input wire logic             upper_serial_in,
  input wire logic [WIDTH-1:0] par_out,
  input wire logic             par_out_oe,
  input wire logic             low_serial_out,
  input wire logic             high_serial_out
);
  logic sclk_q;  // Shift clock at last edge
  logic wr_q;    // Bus write at last edge
  logic quiet;   // No bus restart can land now
  logic moment;  // Shift moment at this edge

  // Past samples; a restart lands the edge after a write
  always_ff @(posedge clk) begin
    if (clk_en) begin
      sclk_q <= shift_clk;
    end
    wr_q <= avs_write;
  end
  assign quiet  = clk_en && !avs_write && !wr_q;
  assign moment = quiet && shift_clk && !sclk_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_low_mirror: assert property (low_serial_out == par_out[0])
    else $error("low serial out differs from bit zero");
  chk_high_mirror: assert property (high_serial_out == par_out[WIDTH-1])
    else $error("high serial out differs from top bit");
  chk_oe_follow: assert property (clk_en |=> par_out_oe == $past(out_en))
    else $error("output enable not followed");
  chk_hold_stops: assert property (quiet && hold && !load && !clear |=> $stable(par_out))
    else $error("contents moved while held");
  chk_up_shift: assert property (moment && dir_up && !hold && !load && !clear
    |=> par_out == {$past(par_out[WIDTH-2:0]), $past(lower_serial_in)})
    else $error("upward shift wrong");
  chk_down_shift: assert property (moment && !dir_up && !hold && !load && !clear
    |=> par_out == {$past(upper_serial_in), $past(par_out[WIDTH-1:1])})
    else $error("downward shift wrong");
  chk_clear_wins: assert property (moment && clear |=> par_out == '0)
    else $error("clear did not win");
  chk_load_wins: assert property (moment && load && !clear |=> par_out == $past(par_in))
    else $error("load did not win over shift");
  chk_reset_zero: assert property (disable iff (1'b0) !rst_n |=> par_out == '0 && !par_out_oe)
    else $error("reset did not clear outputs");
endmodule
bind bidirectional_shift_register shiftreg_checker #(
  .WIDTH(WIDTH), .COUNT_W(COUNT_W)) u_chk (.clk, .rst_n, .clk_en,
  .avs_write, .shift_clk, .dir_up, .hold, .load, .clear, .out_en, .par_in,
  .lower_serial_in, .upper_serial_in, .par_out, .par_out_oe,
  .low_serial_out, .high_serial_out);
`default_nettype wire

// ==== tb/pin_driver.sv ====
`timescale 1ns/1ps
`default_nettype none
// Surrounding logic: drives the shift control and data pins
module pin_driver #(
  parameter int WIDTH = 8
) (
  input  wire logic        clk,
  output logic             shift_clk,
  output logic             dir_up,
  output logic             hold,
  output logic             load,
  output logic             clear,
  output logic             out_en,
  output logic [WIDTH-1:0] par_in,
  output logic             lower_serial_in,
  output logic             upper_serial_in
);
  // Quiet pins; shift clock rests low outside frames
  initial begin
    {shift_clk, dir_up, hold, load, clear, out_en} = 6'h00;
    {par_in, lower_serial_in, upper_serial_in} = '0;
  end

  // One frame: pins and shift clock up, then data turned over
  task automatic step(input logic sc, up, hld, lo, hi, ld, clr, oe,
                      input logic [WIDTH-1:0] pd);
    @(posedge clk);
    shift_clk       <= sc;
    dir_up          <= up;
    hold            <= hld;
    load            <= ld;
    clear           <= clr;
    out_en          <= oe;
    par_in          <= pd;
    lower_serial_in <= lo;
    upper_serial_in <= hi;
    @(posedge clk);
    shift_clk       <= 1'b0;
    load            <= 1'b0;
    clear           <= 1'b0;
    // Stale data inverted so late sampling shows
    par_in          <= ~pd;
    lower_serial_in <= !lo;
    upper_serial_in <= !hi;
  endtask
endmodule
`default_nettype wire

// ==== tb/bidirectional_shift_register_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module bidirectional_shift_register_test;
  localparam int W = 8;
  logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, snap = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hF;
  logic shift_clk, dir_up, hold, load, clear, out_en;
  logic lower_serial_in, upper_serial_in;
  logic low_serial_out, high_serial_out, par_out_oe;
  logic [W-1:0] par_in, par_out;
  logic [W-1:0] m = '0;          // Expected contents
  logic al = 1'b0, ar = 1'b0;    // Expected mode bits
  logic [31:0] seed = 32'h00006CCF;
  logic [31:0] rd_q[$];          // Expected read words
  logic [W:0] pin_q[$];          // Expected oe and contents
  int nsh = 0, compares = 0, miscompares = 0;

  always #2.5 clk = ~clk;

  bidirectional_shift_register #(.WIDTH(W)) u_dut (.clk, .rst_n, .clk_en,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .shift_clk, .dir_up, .hold, .load,
    .clear, .out_en, .par_in, .lower_serial_in, .upper_serial_in,
    .par_out, .par_out_oe, .low_serial_out, .high_serial_out);

  pin_driver #(.WIDTH(W)) u_pins (.clk, .shift_clk, .dir_up, .hold, .load,
    .clear, .out_en, .par_in, .lower_serial_in, .upper_serial_in);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic bad(input string s);
    miscompares++;
    $display("ERROR %0t %s", $time, s);
  endtask

  task automatic cmp_word(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) bad("read word wrong");
  endtask

  task automatic cmp_pins(input logic [W:0] exp);
    compares++;
    if ({par_out_oe, par_out} !== exp || low_serial_out !== exp[0] ||
        high_serial_out !== exp[W-1]) bad("pins wrong");
  endtask

  // Result watcher: oldest note against each answer
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) cmp_word(avs_readdata, rd_q.pop_front());
    if (snap) cmp_pins(pin_q.pop_front());
  end

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_address   <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) bad("bus answer missing");
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // One pin frame, model update, then an output snapshot
  task automatic act(input logic sc, up, hld, ld, clr, oe);
    logic [W-1:0] pd;
    seed = xs(seed);
    pd = seed[W-1:0];
    u_pins.step(sc, up, hld, seed[9], seed[20], ld, clr, oe, pd);
    if (clr && (sc || ar)) m = '0;
    else if (ld && (sc || al)) m = pd;
    else if (sc && !hld) begin
      m = up ? {m[W-2:0], seed[9]} : {seed[20], m[W-1:1]};
      nsh++;
    end
    pin_q.push_back({oe, m});
    snap <= 1'b1;
    @(posedge clk);
    snap <= 1'b0;
  endtask

  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Run is about 125 cycles; 4000 cycles means a hang
  initial begin
    #20000;
    bad("watchdog expired");
    end_sim;
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    act(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rd(shiftreg_pkg::OFS_CTRL, shiftreg_pkg::CTRL_RST);
    rd(shiftreg_pkg::OFS_INIT, shiftreg_pkg::INIT_RST);
    rd(5'h14, shiftreg_pkg::UNMAPPED_RD);
    $display("reset test done");
    act(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 16; i++) begin
      act(1'b1, seed[3], seed[7] & seed[8], 1'b0, 1'b0, seed[5]);
    end
    rd(shiftreg_pkg::OFS_STATUS, 32'(m));
    rd(shiftreg_pkg::OFS_COUNT, 32'(nsh));
    $display("shift test done");
    act(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    act(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    act(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    act(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    $display("priority test done");
    bus(1'b1, shiftreg_pkg::OFS_CTRL, 32'h00000003);
    al = 1'b1;
    ar = 1'b1;
    rd(shiftreg_pkg::OFS_CTRL, 32'h00000003);
    act(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    act(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    bus(1'b1, shiftreg_pkg::OFS_INIT, 32'h000000A5);
    bus(1'b1, shiftreg_pkg::OFS_CTRL, 32'h00000007);
    m = 8'hA5;
    act(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    bus(1'b1, shiftreg_pkg::OFS_STATUS, 32'h000000FF);
    rd(shiftreg_pkg::OFS_STATUS, 32'h000000A5);
    rd(shiftreg_pkg::OFS_PINS, 32'h0000000F);
    rd(shiftreg_pkg::OFS_CTRL, 32'h00000003);
    $display("immediate test done");
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    {m, al, ar} = '0;
    act(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rd(shiftreg_pkg::OFS_CTRL, shiftreg_pkg::CTRL_RST);
    $display("second reset test done");
    end_sim;
  end
endmodule
`default_nettype wire
